// *** rtl/pdmo_pkg.sv ***
// shared constants for the pdm output audio port
package pdmo_pkg;
   // core clock and default master pdm clock
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned PDM_MASTER_HZ = 3_072_000;
   // half period of the master pdm clock in core cycles, rounded down, at least one
   localparam int unsigned MASTER_HALF_RAW = CLK_HZ / (2 * PDM_MASTER_HZ);
   localparam int unsigned MASTER_HALF = (MASTER_HALF_RAW < 1) ? 1 : MASTER_HALF_RAW;
   localparam int unsigned DIV_W = 8;
   // supported slave pdm clock range in khz
   localparam int unsigned PDM_MIN_KHZ = 512;
   localparam int unsigned PDM_MAX_KHZ = 4800;
   // channel counts
   localparam int unsigned TX_CHANS = 2;
   localparam int unsigned RX_CHANS = 4;
   localparam int unsigned MIC_LINES = 2;
   localparam int unsigned RX_CH_W = 2;
   // sample format
   localparam int unsigned SAMPLE_W = 32;
   localparam int unsigned MOD_W = 16;
   // decimation and interpolation ratios in pdm bits per sample
   localparam int unsigned DEC_RATIO = 64;
   localparam int unsigned INTERP_RATIO = 64;
   localparam int unsigned RATIO_W = 7;
   // position of the ones count inside a decimated sample
   localparam int unsigned DEC_SHIFT = 25;
   localparam logic [SAMPLE_W-1:0] MID_SCALE = 32'h80000000;
   localparam logic [RATIO_W-1:0] DEC_FULL = 7'h40;
   localparam logic [RATIO_W-1:0] DEC_CLIP = 7'h3f;
   // reset values
   localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 32'h00000000;
   localparam logic [MOD_W:0] ACC_RST = 17'h00000;
   localparam logic [MOD_W-1:0] SIGN_FLIP = 16'h8000;
   // clocking mode
   typedef enum logic [0:0] {
      PDMO_SLAVE = 1'b0,
      PDMO_MASTER = 1'b1
   } pdmo_mode_t;
   // frame emitter states
   typedef enum logic [0:0] {
      PDMO_IDLE = 1'b0,
      PDMO_EMIT = 1'b1
   } pdmo_emit_t;
endpackage

// *** rtl/pdmo_modulator.sv ***
// one transmit interpolation chain: sample hold plus first order one-bit modulator
`timescale 1ns/1ps
module pdmo_modulator
   import pdmo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_load,
   input wire logic [SAMPLE_W-1:0] i_sample,
   input wire logic i_step,
   output logic o_bit
);
   logic [MOD_W-1:0] hold_q;
   logic [MOD_W-1:0] hold_d;
   logic [MOD_W:0] acc_q;
   logic [MOD_W:0] sum;
   logic bit_q;

   // offset binary of the sample top, so a zero sample gives half density
   assign hold_d = i_sample[SAMPLE_W-1 -: MOD_W] ^ SIGN_FLIP;
   // carry of the error accumulator is the next pdm bit
   assign sum = {1'b0, acc_q[MOD_W-1:0]} + {1'b0, hold_q};

   // zero order hold between loads, accumulator advances once per bit slot
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         hold_q <= SIGN_FLIP;
         acc_q <= ACC_RST;
         bit_q <= 1'b0;
      end
      else
      begin
         if (i_load)
            hold_q <= hold_d;
         if (i_step)
         begin
            acc_q <= sum;
            bit_q <= sum[MOD_W];
         end
      end
   end

   assign o_bit = bit_q;
endmodule

// *** rtl/pdmo_port.sv ***
// two channel pdm output port with receive decimation and stream mux
// Behaviour
// RQ1 - both transmit channels share the single pdm data output line
// RQ2 - one channel bit per clock edge, alternating between the two edges
// RQ3 - pdm clock pin is an input in slave mode, an output in master
// RQ4 - master mode drives the pdm clock near 3.072 mhz by default
// RQ5 - slave mode accepts any listed rate from 512 to 4800 khz
// RQ6 - two independent transmit interpolation chains feed the output path
// RQ7 - each chain turns samples into a one-bit oversampled pdm stream
// RQ8 - four receive decimation chains turn one-bit pdm input into samples
// RQ9 - received audio becomes common 32-bit integer samples before the mux
// RQ10 - received samples are synchronised into the core clock before muxing
// RQ11 - mux gathers samples into n-channel logical streams readable by address
// RQ12 - 32-bit transmit samples are converted into pdm line encoding
// RQ13 - mux offers a low latency path beside its buffered path
// RQ14 - mux captures wall clock timestamps of audio samples
// RQ15 - first channel valid at rising edge, second at falling edge
// RQ16 - slave times output from incoming clock, master from internal divider
`timescale 1ns/1ps
module pdmo_port
   import pdmo_pkg::*;
#(
   parameter int unsigned HALF_DIV = MASTER_HALF
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_master,
   input wire logic i_pdm_clk_in,
   output logic o_pdm_clk_out,
   output logic o_pdm_clk_oe,
   output logic o_pdm_data,
   output logic o_pdm_data_oe,
   input wire logic [TX_CHANS-1:0][SAMPLE_W-1:0] i_tx_data,
   input wire logic [TX_CHANS-1:0] i_tx_valid,
   output logic [TX_CHANS-1:0] o_tx_ready,
   input wire logic [MIC_LINES-1:0] i_mic_data,
   input wire logic [SAMPLE_W-1:0] i_wall_time,
   output logic o_ll_valid,
   output logic [RX_CH_W-1:0] o_ll_chan,
   output logic [SAMPLE_W-1:0] o_ll_data,
   output logic o_strm_valid,
   output logic [RX_CH_W-1:0] o_strm_chan,
   output logic [SAMPLE_W-1:0] o_strm_data,
   output logic [SAMPLE_W-1:0] o_strm_stamp,
   input wire logic [RX_CH_W-1:0] i_rd_chan,
   output logic [SAMPLE_W-1:0] o_rd_data,
   output logic [SAMPLE_W-1:0] o_rd_stamp
);
   localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_DIV - 1);

   // ---- clocking mode and pdm clock edges ----
   pdmo_mode_t mode;
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic mclk_q;
   logic mclk_d;
   logic div_wrap;
   logic [2:0] sclk_q;
   logic s_rise;
   logic s_fall;
   logic m_rise;
   logic m_fall;
   logic pdm_rise;
   logic pdm_fall;

   assign mode = pdmo_mode_t'(i_clk_master);

   // master divider runs from the core clock only
   assign div_wrap = (div_q == HALF_LAST);
   assign div_d = div_wrap ? '0 : div_q + DIV_W'(1);
   assign m_rise = (mode == PDMO_MASTER) && div_wrap && !mclk_q; // [RQ16]
   assign m_fall = (mode == PDMO_MASTER) && div_wrap && mclk_q;
   // next master clock level, so the pin moves on the same edge as the data
   assign mclk_d = div_wrap ? !mclk_q : mclk_q;

   // slave edges come from the synchronised pin; stage 0 read only by stage 1
   assign s_rise = (mode == PDMO_SLAVE) && sclk_q[1] && !sclk_q[2]; // [RQ16] [RQ5]
   assign s_fall = (mode == PDMO_SLAVE) && !sclk_q[1] && sclk_q[2];
   assign pdm_rise = s_rise || m_rise;
   assign pdm_fall = s_fall || m_fall;

   // divider and master clock flop
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || mode == PDMO_SLAVE)
      begin
         div_q <= '0;
         mclk_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         if (div_wrap)
            mclk_q <= !mclk_q; // [RQ4]
      end
   end

   // incoming pdm clock synchroniser
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         sclk_q <= 3'h0;
      else
         sclk_q <= {sclk_q[1:0], i_pdm_clk_in};
   end

   // clock pin direction follows the mode
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_pdm_clk_out <= 1'b0;
         o_pdm_clk_oe <= 1'b0;
      end
      else
      begin
         o_pdm_clk_out <= (mode == PDMO_MASTER) && mclk_d; // [RQ15]
         o_pdm_clk_oe <= (mode == PDMO_MASTER); // [RQ3]
      end
   end

   // ---- transmit path ----
   logic [TX_CHANS-1:0] tx_bit;
   logic [TX_CHANS-1:0] tx_step;
   logic [TX_CHANS-1:0] tx_load;
   logic [RATIO_W-1:0] slot_q;
   logic slot_wrap;

   // chan 0 steps after a falling edge so its new bit is steady at the rise
   assign tx_step[0] = pdm_fall; // [RQ15]
   assign tx_step[1] = pdm_rise; // [RQ15]
   assign slot_wrap = pdm_rise && (slot_q == RATIO_W'(INTERP_RATIO - 1));
   assign tx_load = o_tx_ready & i_tx_valid;

   // one interpolation chain per transmit channel
   generate
      for (genvar c = 0; c < TX_CHANS; c++)
      begin : g_tx
         pdmo_modulator u_mod ( // [RQ6] [RQ7] [RQ12]
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_load(tx_load[c]),
            .i_sample(i_tx_data[c]),
            .i_step(tx_step[c]),
            .o_bit(tx_bit[c])
         );
      end
   endgenerate

   // sample slot counter offers a fresh sample every interp ratio periods
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         slot_q <= '0;
         o_tx_ready <= '0;
      end
      else
      begin
         if (pdm_rise)
            slot_q <= slot_wrap ? '0 : slot_q + RATIO_W'(1);
         o_tx_ready <= slot_wrap ? {TX_CHANS{1'b1}} : o_tx_ready & ~i_tx_valid;
      end
   end

   // shared data line: chan 0 bit after a fall, chan 1 bit after a rise
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_pdm_data <= 1'b0;
         o_pdm_data_oe <= 1'b0;
      end
      else
      begin
         o_pdm_data_oe <= 1'b1; // [RQ1]
         if (pdm_fall)
            o_pdm_data <= tx_bit[0]; // [RQ2]
         else if (pdm_rise)
            o_pdm_data <= tx_bit[1]; // [RQ2]
      end
   end

   // ---- receive decimation ----
   logic [1:0] mic0_q;
   logic [1:0] mic1_q;
   logic [RX_CHANS-1:0] rx_bit;
   logic [RX_CHANS-1:0] rx_edge;
   logic [RX_CHANS-1:0] rx_done;
   logic [RX_CHANS-1:0][RATIO_W-1:0] ones_q;
   logic [RX_CHANS-1:0][RATIO_W-1:0] cnt_q;
   logic [RX_CHANS-1:0][SAMPLE_W-1:0] rx_sample;

   // microphone lines cross into the core clock through two flops
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         mic0_q <= 2'h0;
         mic1_q <= 2'h0;
      end
      else
      begin
         mic0_q <= {mic0_q[0], i_mic_data[0]}; // [RQ10]
         mic1_q <= {mic1_q[0], i_mic_data[1]}; // [RQ10]
      end
   end

   // even chains sample at the rise, odd chains at the fall
   assign rx_bit = {mic1_q[1], mic1_q[1], mic0_q[1], mic0_q[1]};
   assign rx_edge = {pdm_fall, pdm_rise, pdm_fall, pdm_rise};

   // integrate and dump per chain, ones count shifted up by DEC_SHIFT, then MID_SCALE subtracted
   generate
      for (genvar r = 0; r < RX_CHANS; r++)
      begin : g_rx
         logic [RATIO_W-1:0] total;
         logic [RATIO_W-1:0] clip;
         assign total = ones_q[r] + RATIO_W'(rx_bit[r]);
         assign clip = (total == DEC_FULL) ? DEC_CLIP : total;
         assign rx_done[r] = rx_edge[r] && (cnt_q[r] == RATIO_W'(DEC_RATIO - 1));
         assign rx_sample[r] = ({{(SAMPLE_W-RATIO_W){1'b0}}, clip} << DEC_SHIFT) - MID_SCALE; // [RQ9]

         always_ff @(posedge i_clk)
         begin
            if (!i_rst_b)
            begin
               ones_q[r] <= '0;
               cnt_q[r] <= '0;
            end
            else if (rx_edge[r])
            begin
               ones_q[r] <= rx_done[r] ? '0 : total; // [RQ8]
               cnt_q[r] <= rx_done[r] ? '0 : cnt_q[r] + RATIO_W'(1);
            end
         end
      end
   endgenerate

   // ---- stream mux ----
   logic [SAMPLE_W-1:0] buf_data [RX_CHANS];
   logic [SAMPLE_W-1:0] buf_stamp [RX_CHANS];
   logic [RX_CHANS-1:0] fresh_q;
   logic [RX_CH_W-1:0] done_idx;
   logic any_done;
   pdmo_emit_t emit_q;
   logic [RX_CH_W-1:0] emit_idx_q;
   logic emit_last;

   // lowest finishing chain wins the low latency slot this cycle
   assign any_done = |rx_done;
   assign done_idx = rx_done[0] ? 2'h0 : rx_done[1] ? 2'h1 : rx_done[2] ? 2'h2 : 2'h3;
   assign emit_last = (emit_idx_q == RX_CH_W'(RX_CHANS - 1));

   // buffered copy of each chain with its timestamp
   always_ff @(posedge i_clk)
   begin
      for (int k = 0; k < RX_CHANS; k++)
      begin
         if (!i_rst_b)
         begin
            buf_data[k] <= SAMPLE_RST;
            buf_stamp[k] <= SAMPLE_RST;
         end
         else if (rx_done[k])
         begin
            buf_data[k] <= rx_sample[k]; // [RQ11]
            buf_stamp[k] <= i_wall_time; // [RQ14]
         end
      end
   end

   // low latency path passes a sample the cycle after it is decimated
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_ll_valid <= 1'b0;
         o_ll_chan <= '0;
         o_ll_data <= SAMPLE_RST;
      end
      else
      begin
         o_ll_valid <= any_done; // [RQ13]
         o_ll_chan <= done_idx;
         o_ll_data <= rx_sample[done_idx];
      end
   end

   // frame emitter: once all chains are fresh, emits an n-channel frame
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         emit_q <= PDMO_IDLE;
         emit_idx_q <= '0;
         fresh_q <= '0;
         o_strm_valid <= 1'b0;
         o_strm_chan <= '0;
         o_strm_data <= SAMPLE_RST;
         o_strm_stamp <= SAMPLE_RST;
      end
      else
      begin
         o_strm_valid <= 1'b0;
         case (emit_q)
            PDMO_IDLE:
            begin
               fresh_q <= fresh_q | rx_done;
               emit_idx_q <= '0;
               if (&fresh_q)
               begin
                  emit_q <= PDMO_EMIT;
                  fresh_q <= rx_done;
               end
            end
            PDMO_EMIT:
            begin
               fresh_q <= fresh_q | rx_done;
               o_strm_valid <= 1'b1; // [RQ11]
               o_strm_chan <= emit_idx_q;
               o_strm_data <= buf_data[emit_idx_q];
               o_strm_stamp <= buf_stamp[emit_idx_q]; // [RQ14]
               emit_idx_q <= emit_idx_q + RX_CH_W'(1);
               if (emit_last)
                  emit_q <= PDMO_IDLE;
            end
            default:
               emit_q <= PDMO_IDLE;
         endcase
      end
   end

   // addressed read of the latest sample of any chain
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rd_data <= SAMPLE_RST;
         o_rd_stamp <= SAMPLE_RST;
      end
      else
      begin
         o_rd_data <= buf_data[i_rd_chan]; // [RQ11]
         o_rd_stamp <= buf_stamp[i_rd_chan];
      end
   end
endmodule

// *** verification/pdmo_port_props.sv ***
// pin level checks for the pdm output port
`timescale 1ns/1ps
module pdmo_port_props
   import pdmo_pkg::*;
#(
   parameter int unsigned HALF_DIV = MASTER_HALF
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_master,
   input wire logic o_pdm_clk_out,
   input wire logic o_pdm_clk_oe,
   input wire logic o_pdm_data,
   input wire logic o_pdm_data_oe,
   input wire logic [TX_CHANS-1:0] i_tx_valid,
   input wire logic [TX_CHANS-1:0] o_tx_ready,
   input wire logic o_ll_valid,
   input wire logic [SAMPLE_W-1:0] o_ll_data,
   input wire logic o_strm_valid,
   input wire logic [RX_CH_W-1:0] o_strm_chan
);
   logic [DIV_W-1:0] hi_cnt_q;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // length of the running high phase
   always_ff @(posedge i_clk)
      if (!i_rst_b || !o_pdm_clk_out)
         hi_cnt_q <= '0;
      else
         hi_cnt_q <= hi_cnt_q + 1'b1;
   property p_clk_oe;
      $past(i_rst_b) |-> o_pdm_clk_oe == $past(i_clk_master);
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock enable not following mode");
   property p_slave_quiet;
      !o_pdm_clk_oe && !$past(o_pdm_clk_oe) |-> !o_pdm_clk_out;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven in slave mode");
   property p_half;
      disable iff (!i_rst_b || !i_clk_master) $fell(o_pdm_clk_out) |-> hi_cnt_q == HALF_DIV;
   endproperty
   a_half: assert property (p_half) else $error("master high phase length wrong");
   property p_data_edge;
      o_pdm_clk_oe && $past(o_pdm_clk_oe, 4) && $changed(o_pdm_data) |-> $changed(o_pdm_clk_out);
   endproperty
   a_data_edge: assert property (p_data_edge) else $error("data moved away from a clock edge");
   property p_data_oe;
      $past(i_rst_b) |-> o_pdm_data_oe;
   endproperty
   a_data_oe: assert property (p_data_oe) else $error("data line not driven");
   property p_tx_take;
      (o_tx_ready & i_tx_valid) != '0 |=> (o_tx_ready & $past(o_tx_ready & i_tx_valid)) == '0;
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("ready stayed after take");
   property p_ll_pulse;
      o_ll_valid |=> !o_ll_valid;
   endproperty
   a_ll_pulse: assert property (p_ll_pulse) else $error("low latency pulse too long");
   property p_ll_fmt;
      o_ll_valid |-> o_ll_data[DEC_SHIFT-1:0] == '0;
   endproperty
   a_ll_fmt: assert property (p_ll_fmt) else $error("sample format low bits set");
   property p_frame;
      o_strm_valid && o_strm_chan == 2'h0 |-> $past(o_ll_valid, 2) ##1 (o_strm_valid && o_strm_chan == 2'h1)
         ##1 (o_strm_valid && o_strm_chan == 2'h2) ##1 (o_strm_valid && o_strm_chan == 2'h3) ##1 !o_strm_valid;
   endproperty
   a_frame: assert property (p_frame) else $error("stream frame order wrong");
endmodule

// *** verification/pdmo_host.sv ***
// far side model: pdm clock source in slave mode and two channel bit receiver
`timescale 1ns/1ps
module pdmo_host
(
   input wire logic i_clk,
   input wire logic i_drive,
   input wire logic i_pdm_clk,
   input wire logic i_pdm_data,
   output logic o_pdm_clk
);
   int half_ns = 200;
   logic d_hold;
   logic q_rise[$];
   logic q_fall[$];
   // clock source, still low outside frames
   initial
   begin
      o_pdm_clk = 1'b0;
      #13;
      forever
         if (i_drive)
         begin
            #(half_ns) o_pdm_clk = 1'b1;
            #(half_ns) o_pdm_clk = 1'b0;
         end
         else
            #50;
   end
   // value before a master edge, which moves data on the same core edge
   always @(negedge i_clk)
      d_hold <= i_pdm_data;
   // first channel read at rise, second at fall
   always @(posedge i_pdm_clk)
      q_rise.push_back(i_drive ? i_pdm_data : d_hold);
   always @(negedge i_pdm_clk)
      q_fall.push_back(i_drive ? i_pdm_data : d_hold);
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the pdm output port
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) \
      begin \
         bad_count++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module testbench
   import pdmo_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_clk_master = 1'b0;
   logic drive = 1'b0;
   logic [TX_CHANS-1:0][SAMPLE_W-1:0] i_tx_data = '0;
   logic [TX_CHANS-1:0][SAMPLE_W-1:0] want = '0;
   logic [TX_CHANS-1:0] i_tx_valid = '1;
   logic [TX_CHANS-1:0] tx_ready;
   logic [TX_CHANS-1:0] took = '0;
   logic [MIC_LINES-1:0] i_mic_data = '0;
   logic [SAMPLE_W-1:0] i_wall_time = '0;
   logic [RX_CH_W-1:0] i_rd_chan = '0;
   logic [RX_CH_W-1:0] strm_chan;
   logic [SAMPLE_W-1:0] strm_data, rd_data;
   logic [SAMPLE_W-1:0] last_strm [RX_CHANS];
   logic clk_out, clk_oe, data, data_oe, host_clk, strm_valid;
   int bad_count = 0;
   int tests_run = 0;
   int unsigned seed = 58089;
   wire pin_clk = clk_oe ? clk_out : host_clk;
   wire pin_data = data_oe ? data : ~data;
   initial forever #25 i_clk = ~i_clk;
   pdmo_port #(.HALF_DIV(3)) u_pdmo_port (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_clk_master(i_clk_master),
      .i_pdm_clk_in(pin_clk), .o_pdm_clk_out(clk_out), .o_pdm_clk_oe(clk_oe), .o_pdm_data(data),
      .o_pdm_data_oe(data_oe), .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(tx_ready),
      .i_mic_data(i_mic_data), .i_wall_time(i_wall_time), .o_ll_valid(), .o_ll_chan(), .o_ll_data(),
      .o_strm_valid(strm_valid), .o_strm_chan(strm_chan), .o_strm_data(strm_data), .o_strm_stamp(),
      .i_rd_chan(i_rd_chan), .o_rd_data(rd_data), .o_rd_stamp());
   pdmo_host host (.i_clk(i_clk), .i_drive(drive), .i_pdm_clk(pin_clk), .i_pdm_data(pin_data), .o_pdm_clk(host_clk));
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // watch takes and stream frames
   always @(posedge i_clk)
   begin
      took <= tx_ready & i_tx_valid;
      if (strm_valid)
         last_strm[strm_chan] <= strm_data;
   end
   // wall clock, new sample offered only after a take
   always @(negedge i_clk)
   begin
      i_wall_time <= i_wall_time + 1'b1;
      for (int c = 0; c < TX_CHANS; c++)
         if (took[c])
            i_tx_data[c] <= want[c];
   end
   task automatic round(input int r);
      int n0, n1, e0, e1;
      int unsigned t;
      logic [SAMPLE_W-1:0] ex;
      @(negedge i_clk);
      i_clk_master = r[0];
      drive = !r[0];
      host.half_ns = (r == 2) ? 977 : 200;
      t = xs();
      i_mic_data = t[1:0];
      i_rd_chan = t[3:2];
      want[0] = xs();
      want[1] = xs();
      repeat (20) @(negedge i_clk);
      host.q_rise.delete();
      host.q_fall.delete();
      for (int w = 0; w < 12000 && host.q_fall.size() < 240; w++)
         @(negedge i_clk);
      `CHK("clock enable", r[0], clk_oe)
      `CHK("bits seen", 1'b1, host.q_fall.size() >= 240)
      n0 = 0;
      n1 = 0;
      for (int i = 1; i <= 64; i++)
      begin
         n0 += (host.q_rise[host.q_rise.size()-i] === 1'b1);
         n1 += (host.q_fall[host.q_fall.size()-i] === 1'b1);
      end
      e0 = (64 * int'(want[0][31:16] ^ SIGN_FLIP)) >> 16;
      e1 = (64 * int'(want[1][31:16] ^ SIGN_FLIP)) >> 16;
      `CHK("chan0 density", e0, (n0 - e0 <= 2 && e0 - n0 <= 2) ? e0 : n0)
      `CHK("chan1 density", e1, (n1 - e1 <= 2 && e1 - n1 <= 2) ? e1 : n1)
      for (int c = 0; c < RX_CHANS; c++)
      begin
         ex = (i_mic_data[c/2] ? {25'h0, DEC_CLIP} << DEC_SHIFT : 32'h0) - MID_SCALE;
         `CHK("stream sample", ex, last_strm[c])
         if (c == i_rd_chan)
            `CHK("read port", ex, rd_data)
      end
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // reset, then slave and master rounds
   initial
   begin
      repeat (20) @(negedge i_clk);
      i_rst_b = 1'b1;
      for (int r = 0; r < 4; r++)
         round(r);
      tally_and_finish();
   end
   // hang guard
   initial
   begin
      repeat (40000) @(posedge i_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
bind pdmo_port pdmo_port_props #(.HALF_DIV(HALF_DIV)) u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_clk_master(i_clk_master), .o_pdm_clk_out(o_pdm_clk_out), .o_pdm_clk_oe(o_pdm_clk_oe),
   .o_pdm_data(o_pdm_data), .o_pdm_data_oe(o_pdm_data_oe), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
   .o_ll_valid(o_ll_valid), .o_ll_data(o_ll_data), .o_strm_valid(o_strm_valid), .o_strm_chan(o_strm_chan));
